// >>> src/dual_serial_port_addr_match.sv
// two serial ports with address recognition behind an axi4-lite slave
// Overview of operation
// - port 0 control bit 7 is mode bit or framing flag, per frame_err_select.
// - framing flag sets on bad stop bit, stays until software clears it.
// - mode bits pick sync 8-bit, async 10-bit, async 11-bit fixed, async 11-bit variable.
// - modes 2/3 with addressed reception: no receive flag when ninth bit is 0.
// - mode 1 with addressed reception: no receive flag without valid stop bit.
// - mode 0 shift clock is oscillator over 12, or over 4 with addressed_reception.
// - receiver starts only while rx_enable is 1; clearing it drops an async frame, but a mode 0 byte still completes.
// - modes 2/3 send tx_ninth_bit as the ninth data bit.
// - rx_ninth_bit holds ninth bit in modes 2/3, stop bit in mode 1.
// - transmit flag sets after eighth bit in mode 0, at stop start otherwise.
// - receive flag sets after eighth bit in mode 0, mid-stop otherwise.
// - hardware never clears the receive flag; software clears it per frame.
// - data buffer address reads receive register, writes load transmit buffer.
// - masked station address bits are compared, unmasked ones are don't-care.
// - an all-zero mask matches any incoming address.
// - port 1 has its own station address and mask, same matching.
// - port 1 control top bit is also mode bit or framing flag.
// - port interrupts pass only with their own enable and the global enable.
// - each port's level bit selects the higher interrupt priority.
// - port 1 offers the same four modes, lengths and rates.
`include "dual_serial_port_regs.svh"

module dual_serial_port_addr_match
	import serial_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [9:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [9:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic port0_rxd_in, // port 0 receive pin level
	output logic port0_rxd_out, // port 0 receive pin drive in mode 0
	output logic port0_rxd_oe, // port 0 receive pin enable
	output logic port0_txd, // port 0 transmit line or shift clock
	input wire logic port1_rxd_in, // port 1 receive pin level
	output logic port1_rxd_out, // port 1 receive pin drive in mode 0
	output logic port1_rxd_oe, // port 1 receive pin enable
	output logic port1_txd, // port 1 transmit line or shift clock
	output logic irq_port0, // port 0 interrupt request
	output logic irq_port1, // port 1 interrupt request
	output logic irq_level_port0, // port 0 high priority
	output logic irq_level_port1 // port 1 high priority
);

	logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] wr_idx_r, wr_byte_r, misc_r, rd_byte;
	logic wr_strb_r, do_write, wr_hit, wr_mapped, rd_mapped;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic rxd_pin [2];
	logic [7:0] ctrl_view [2];
	logic [7:0] rxbuf_view [2];
	logic [7:0] port0_station_address_view [2];
	logic [7:0] mask_view [2];
	logic [7:0] baud_view [2];
	logic txd_o [2];
	logic rxd_out_o [2];
	logic rxd_oe_o [2];
	logic irq_o [2];
	logic lvl_o [2];

	assign rxd_pin[0] = port0_rxd_in;
	assign rxd_pin[1] = port1_rxd_in;
	assign port0_txd = txd_o[0];
	assign port1_txd = txd_o[1];
	assign port0_rxd_out = rxd_out_o[0];
	assign port1_rxd_out = rxd_out_o[1];
	assign port0_rxd_oe = rxd_oe_o[0];
	assign port1_rxd_oe = rxd_oe_o[1];
	assign irq_port0 = irq_o[0];
	assign irq_port1 = irq_o[1];
	assign irq_level_port0 = lvl_o[0];
	assign irq_level_port1 = lvl_o[1];
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// a write happens once both halves are held; byte lane 0 carries the register
	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign wr_hit = do_write && wr_strb_r && wr_mapped;

	// decode of the write index
	always_comb begin
		unique case (wr_idx_r)
			`IDX_CTRL0, `IDX_DATA0, `IDX_SADDR0, `IDX_PORT1_STATION_ADDRESS, `IDX_MASK0, `IDX_MASK1,
			`IDX_CTRL1, `IDX_DATA1, `IDX_MISC, `IDX_BAUD0, `IDX_BAUD1: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// write channels: address and data taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			wr_idx_r <= `RST_BYTE;
			wr_byte_r <= `RST_BYTE;
			wr_strb_r <= 1'b0;
		end else begin
			if (awvalid && awready_r) begin
				aw_held_r <= 1'b1;
				awready_r <= 1'b0;
				wr_idx_r <= awaddr[9:2];
			end
			if (wvalid && wready_r) begin
				w_held_r <= 1'b1;
				wready_r <= 1'b0;
				wr_byte_r <= wdata[7:0];
				wr_strb_r <= wstrb[0];
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// read mux; reading has no side effect, unmapped indices answer slverr
	always_comb begin
		rd_mapped = 1'b1;
		unique case (araddr[9:2])
			`IDX_CTRL0: rd_byte = ctrl_view[0];
			`IDX_DATA0: rd_byte = rxbuf_view[0];
			`IDX_SADDR0: rd_byte = port0_station_address_view[0];
			`IDX_PORT1_STATION_ADDRESS: rd_byte = port0_station_address_view[1];
			`IDX_MASK0: rd_byte = mask_view[0];
			`IDX_MASK1: rd_byte = mask_view[1];
			`IDX_CTRL1: rd_byte = ctrl_view[1];
			`IDX_DATA1: rd_byte = rxbuf_view[1];
			`IDX_MISC: rd_byte = misc_r;
			`IDX_BAUD0: rd_byte = baud_view[0];
			`IDX_BAUD1: rd_byte = baud_view[1];
			default: begin
				rd_byte = `RST_BYTE;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// read channel answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= {24'h000000, `RST_BYTE};
			rresp_r <= `RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_byte};
			rresp_r <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// shared configuration: frame flag select, enables, levels, mode 2 rate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			misc_r <= `RST_BYTE;
		end else if (wr_hit && wr_idx_r == `IDX_MISC) begin
			misc_r <= {1'b0, wr_byte_r[6:0]};
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam logic [7:0] IDX_CTRL = (p == 0) ? `IDX_CTRL0 : `IDX_CTRL1;
		localparam logic [7:0] IDX_DATA = (p == 0) ? `IDX_DATA0 : `IDX_DATA1;
		localparam logic [7:0] IDX_PORT0_STATION_ADDRESS = (p == 0) ? `IDX_SADDR0 : `IDX_PORT1_STATION_ADDRESS;
		localparam logic [7:0] IDX_MASK = (p == 0) ? `IDX_MASK0 : `IDX_MASK1;
		localparam logic [7:0] IDX_BAUD = (p == 0) ? `IDX_BAUD0 : `IDX_BAUD1;
		logic [7:0] ctrl_r, rxbuf_r, port0_station_address_r, mask_r, baud_r, m0_rx_r;
		logic fe_r, rx_s1, rx_s2, rx_s3, txd_r, rxd_out_r, rxd_oe_r, irq_r, lvl_r;
		logic wr_ctrl, wr_data, fes, sm2, ti_set, m0_rx_done, accept, fe_set, stop, match;
		logic [12:0] bit_len, half, sh_cnt_r, rx_cnt_r;
		logic [3:0] sh_bits_r, rx_bits_r, last_data, sh_last;
		logic [10:0] sh_reg_r;
		logic [9:0] frame_r;
		frame_mode_t mode;
		shift_state_t sh_state_r;
		rx_state_t rx_state_r;

		assign wr_ctrl = wr_hit && wr_idx_r == IDX_CTRL;
		assign wr_data = wr_hit && wr_idx_r == IDX_DATA;
		assign fes = misc_r[`MISC_FE_SEL];
		assign sm2 = ctrl_r[`CTL_ADDR_RX];
		// mode from the two mode bits
		assign mode = frame_mode_t'(ctrl_r[`CTL_MODE_HI:`CTL_MODE_LO]);
		// top bit shows flag or mode bit
		assign ctrl_view[p] = {fes ? fe_r : ctrl_r[`CTL_MODE_HI], ctrl_r[6:0]};
		assign rxbuf_view[p] = rxbuf_r;
		assign port0_station_address_view[p] = port0_station_address_r;
		assign mask_view[p] = mask_r;
		assign baud_view[p] = baud_r;
		assign txd_o[p] = txd_r;
		assign rxd_out_o[p] = rxd_out_r;
		assign rxd_oe_o[p] = rxd_oe_r;
		assign irq_o[p] = irq_r;
		assign lvl_o[p] = lvl_r;

		// bit time per mode; variable rate is sixteen clocks per divisor step
		always_comb begin
			unique case (mode)
				// mode 0 clock divide by 12 or 4
				MODE_SYNC: bit_len = sm2 ? `M0_DIV_FAST : `M0_DIV_SLOW;
				MODE_ASYNC11_FIXED: bit_len = misc_r[`MISC_DOUBLE] ? `M2_BIT_FAST : `M2_BIT_SLOW;
				MODE_ASYNC10, MODE_ASYNC11_VAR: bit_len = (13'(baud_r) + 13'd1) << `BAUD_SHIFT;
			endcase
		end
		assign half = bit_len >> 1;
		assign last_data = (mode == MODE_ASYNC10) ? `LAST_DATA_10 : `LAST_DATA_11;
		assign sh_last = (sh_state_r == SH_TX_ASYNC) ? 4'(last_data + 4'd1) : `LAST_M0;

		// station address, mask and baud divisor
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				port0_station_address_r <= `RST_BYTE;
				mask_r <= `RST_BYTE;
				baud_r <= `RST_BYTE;
			end else begin
				if (wr_hit && wr_idx_r == IDX_PORT0_STATION_ADDRESS) port0_station_address_r <= wr_byte_r;
				if (wr_hit && wr_idx_r == IDX_MASK) mask_r <= wr_byte_r;
				if (wr_hit && wr_idx_r == IDX_BAUD) baud_r <= wr_byte_r;
			end
		end

		// shift unit: async transmit, and both directions of mode 0 on the shared pins
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sh_state_r <= SH_IDLE;
				sh_cnt_r <= 13'd0;
				sh_bits_r <= 4'd0;
				sh_reg_r <= 11'h000;
				m0_rx_r <= `RST_BYTE;
			end else begin
				unique case (sh_state_r)
					SH_IDLE: begin
						sh_cnt_r <= 13'd0;
						sh_bits_r <= 4'd0;
						if (wr_data) begin
							if (mode == MODE_SYNC) begin
								sh_reg_r <= {3'b111, wr_byte_r};
								sh_state_r <= SH_M0_TX;
							end else begin
								sh_reg_r <= {1'b1, (mode == MODE_ASYNC10) | ctrl_r[`CTL_TX9],
									wr_byte_r, 1'b0};
								sh_state_r <= SH_TX_ASYNC;
							end
						// mode 0 receive only with rx_enable
						end else if (mode == MODE_SYNC && ctrl_r[`CTL_RX_EN] && !ctrl_r[`CTL_RI]) begin
							sh_state_r <= SH_M0_RX;
						end
					end
					SH_TX_ASYNC, SH_M0_TX, SH_M0_RX: begin
						sh_cnt_r <= (sh_cnt_r == bit_len - 13'd1) ? 13'd0 : sh_cnt_r + 13'd1;
						// mode 0 input sampled at the rising edge of the shift clock
						if (sh_state_r == SH_M0_RX && sh_cnt_r == half) m0_rx_r <= {rx_s2, m0_rx_r[7:1]};
						if (sh_cnt_r == bit_len - 13'd1) begin
							sh_bits_r <= sh_bits_r + 4'd1;
							sh_reg_r <= {1'b1, sh_reg_r[10:1]};
							if (sh_bits_r == sh_last) sh_state_r <= SH_IDLE;
						end
					end
				endcase
			end
		end

		// transmit flag at end of bit 8 in mode 0, at stop start otherwise
		assign ti_set = (sh_cnt_r == bit_len - 13'd1) &&
			((sh_state_r == SH_TX_ASYNC && sh_bits_r == last_data) ||
			(sh_state_r == SH_M0_TX && sh_bits_r == `LAST_M0));
		assign m0_rx_done = sh_state_r == SH_M0_RX && sh_cnt_r == bit_len - 13'd1 &&
			sh_bits_r == `LAST_M0;

		// pin drivers; mode 0 clock is low for the first half of each bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				txd_r <= 1'b1;
				rxd_out_r <= 1'b1;
				rxd_oe_r <= 1'b0;
			end else begin
				txd_r <= (sh_state_r == SH_TX_ASYNC) ? sh_reg_r[0] :
					(sh_state_r == SH_IDLE) | (sh_cnt_r >= half);
				rxd_out_r <= (sh_state_r == SH_M0_TX) ? sh_reg_r[0] : 1'b1;
				rxd_oe_r <= sh_state_r == SH_M0_TX;
			end
		end

		// receive pin synchroniser; the third stage feeds the start edge detect
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rx_s1 <= 1'b1;
				rx_s2 <= 1'b1;
				rx_s3 <= 1'b1;
			end else begin
				rx_s1 <= rxd_pin[p];
				rx_s2 <= rx_s1;
				rx_s3 <= rx_s2;
			end
		end

		// async receiver: start checked at half bit, then every bit at its middle
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rx_state_r <= RX_IDLE;
				rx_cnt_r <= 13'd0;
				rx_bits_r <= 4'd0;
				frame_r <= 10'h000;
			end else if (rx_state_r != RX_IDLE && !ctrl_r[`CTL_RX_EN]) begin
				// clearing rx_enable drops a frame in flight
				rx_state_r <= RX_IDLE;
			end else begin
				unique case (rx_state_r)
					RX_IDLE: begin
						rx_cnt_r <= 13'd0;
						rx_bits_r <= 4'd0;
						// start only while rx_enable is set
						if (ctrl_r[`CTL_RX_EN] && mode != MODE_SYNC && rx_s3 && !rx_s2)
							rx_state_r <= RX_START;
					end
					RX_START: begin
						rx_cnt_r <= rx_cnt_r + 13'd1;
						if (rx_cnt_r == half) begin
							rx_cnt_r <= 13'd0;
							rx_state_r <= rx_s2 ? RX_IDLE : RX_BITS;
						end
					end
					RX_BITS: begin
						rx_cnt_r <= rx_cnt_r + 13'd1;
						if (rx_cnt_r == bit_len - 13'd1) begin
							rx_cnt_r <= 13'd0;
							frame_r[rx_bits_r] <= rx_s2;
							rx_bits_r <= rx_bits_r + 4'd1;
							if (rx_bits_r == last_data) rx_state_r <= RX_DONE;
						end
					end
					RX_DONE: rx_state_r <= RX_IDLE;
				endcase
			end
		end

		// an empty mask matches every address
		assign match = ((frame_r[7:0] ^ port0_station_address_r) & mask_r) == 8'h00;
		assign stop = (mode == MODE_ASYNC10) ? frame_r[8] : frame_r[9];
		// ninth bit 0 is dropped under addressed reception
		// mode 1 needs a valid stop under addressed reception
		// receive flag one cycle after the mid-stop sample
		assign accept = rx_state_r == RX_DONE && !ctrl_r[`CTL_RI] &&
			((mode == MODE_ASYNC10) ? (!sm2 || stop) : (!sm2 || (frame_r[8] && match)));
		assign fe_set = rx_state_r == RX_DONE && !stop;

		// receive register; an unread frame is kept while the receive flag is up
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				rxbuf_r <= `RST_BYTE;
			end else if (accept) begin
				rxbuf_r <= frame_r[7:0];
			end else if (m0_rx_done) begin
				rxbuf_r <= m0_rx_r;
			end
		end

		// control register; hardware sets come last so they win over a clear
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctrl_r <= `RST_BYTE;
			end else begin
				if (wr_ctrl) begin
					ctrl_r[6:0] <= wr_byte_r[6:0];
					if (!fes) ctrl_r[`CTL_MODE_HI] <= wr_byte_r[`CTL_MODE_HI];
				end
				// ninth bit or stop bit captured
				if (accept) ctrl_r[`CTL_RX9] <= frame_r[8];
				if (ti_set) ctrl_r[`CTL_TI] <= 1'b1;
				// set at end of bit 8 in mode 0
				// only set here, never cleared by hardware
				if (accept || m0_rx_done) ctrl_r[`CTL_RI] <= 1'b1;
			end
		end

		// framing flag sticky until software writes a 0
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				fe_r <= 1'b0;
			end else if (fe_set) begin
				fe_r <= 1'b1;
			end else if (wr_ctrl && fes && !wr_byte_r[`CTL_MODE_HI]) begin
				fe_r <= 1'b0;
			end
		end

		// interrupt request and priority level
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				irq_r <= 1'b0;
				lvl_r <= 1'b0;
			end else begin
				irq_r <= misc_r[`MISC_ALL_EN] && misc_r[`MISC_EN0 + p] &&
					(ctrl_r[`CTL_TI] || ctrl_r[`CTL_RI]);
				lvl_r <= misc_r[`MISC_LVL0 + p];
			end
		end
	end

endmodule

// >>> pkg/dual_serial_port_regs.svh
// register indices, field positions, reset values and timing counts of the dual serial port
`ifndef DUAL_SERIAL_PORT_REGS_SVH
`define DUAL_SERIAL_PORT_REGS_SVH

// register indices; byte address is four times the index
`define IDX_CTRL0 8'h98
`define IDX_DATA0 8'h99
`define IDX_SADDR0 8'ha9
`define IDX_PORT1_STATION_ADDRESS 8'haa
`define IDX_MASK0 8'hb9
`define IDX_MASK1 8'hba
`define IDX_CTRL1 8'hc0
`define IDX_DATA1 8'hc1
`define IDX_MISC 8'hd0
`define IDX_BAUD0 8'hd1
`define IDX_BAUD1 8'hd2

// control register fields
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_ADDR_RX 5
`define CTL_RX_EN 4
`define CTL_TX9 3
`define CTL_RX9 2
`define CTL_TI 1
`define CTL_RI 0

// misc configuration fields
`define MISC_FE_SEL 0
`define MISC_ALL_EN 1
`define MISC_EN0 2
`define MISC_LVL0 4
`define MISC_DOUBLE 6

`define RST_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// bit times in clock periods
`define M0_DIV_SLOW 13'd12
`define M0_DIV_FAST 13'd4
`define M2_BIT_SLOW 13'd64
`define M2_BIT_FAST 13'd32
`define BAUD_SHIFT 4

// last frame bit indices
`define LAST_M0 4'd7
`define LAST_DATA_10 4'd8
`define LAST_DATA_11 4'd9

`endif

// >>> pkg/serial_pkg.sv
// types shared by the dual serial port
package serial_pkg;
	typedef enum logic [1:0] {
		MODE_SYNC,
		MODE_ASYNC10,
		MODE_ASYNC11_FIXED,
		MODE_ASYNC11_VAR
	} frame_mode_t;
	typedef enum {SH_IDLE, SH_TX_ASYNC, SH_M0_TX, SH_M0_RX} shift_state_t;
	typedef enum {RX_IDLE, RX_START, RX_BITS, RX_DONE} rx_state_t;
endpackage

// >>> tb/serial_port_asserts.sv
// bound checks on the dual serial port pins
`include "dual_serial_port_regs.svh"
module serial_port_asserts (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic [9:0] awaddr, // write address
	input wire logic awvalid, // address valid
	input wire logic awready, // address ready
	input wire logic [31:0] wdata, // write data
	input wire logic wvalid, // data valid
	input wire logic wready, // data ready
	input wire logic [31:0] rdata, // read data
	input wire logic rvalid, // read valid
	input wire logic port0_txd, // line or shift clock
	input wire logic port0_rxd_oe, // data pin enable
	input wire logic irq_port0, // port 0 request
	input wire logic irq_port1, // port 1 request
	input wire logic irq_level_port0, // port 0 priority
	input wire logic irq_level_port1 // port 1 priority
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] misc_r;
	logic [2:0] mode_r;
	logic [3:0] falls_r;
	logic txd_r;
	logic take;
	// the bench offers both channels together, so a write lands at one edge
	assign take = awvalid && awready && wvalid && wready;
	// config shadow; the design trails it by two edges, hence the 4-cycle windows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			misc_r <= 8'h00;
		end else if (take && awaddr[9:2] == `IDX_MISC) begin
			misc_r <= wdata[7:0];
		end
	end
	// mode shadow; top bit frozen while it serves as the error flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= 3'h0;
		end else if (take && awaddr[9:2] == `IDX_CTRL0) begin
			mode_r <= {misc_r[`MISC_FE_SEL] ? mode_r[2] : wdata[7], wdata[6:5]};
		end
	end
	// shift clock falls while the data pin is driven
	always_ff @(posedge aclk) begin
		txd_r <= port0_txd;
		if (!port0_rxd_oe) begin
			falls_r <= 4'h0;
		end else if (txd_r && !port0_txd) begin
			falls_r <= falls_r + 4'h1;
		end
	end
	default clocking dck @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_irq0_gate;
		(!(misc_r[`MISC_ALL_EN] && misc_r[`MISC_EN0])) [*4] |-> !irq_port0;
	endproperty
	a_irq0_gate: assert property (p_irq0_gate)
		else $error("port 0 request while masked");
	property p_irq1_gate;
		(!(misc_r[`MISC_ALL_EN] && misc_r[3])) [*4] |-> !irq_port1;
	endproperty
	a_irq1_gate: assert property (p_irq1_gate)
		else $error("port 1 request while masked");
	property p_lvl0;
		$stable(misc_r[`MISC_LVL0]) [*4] |-> irq_level_port0 == misc_r[`MISC_LVL0];
	endproperty
	a_lvl0: assert property (p_lvl0)
		else $error("port 0 priority differs from its bit");
	property p_lvl1;
		$stable(misc_r[5]) [*4] |-> irq_level_port1 == misc_r[5];
	endproperty
	a_lvl1: assert property (p_lvl1)
		else $error("port 1 priority differs from its bit");
	property p_m0_slow;
		$fell(port0_txd) && mode_r == 3'h0 |=> !port0_txd [*5] ##1 port0_txd [*6];
	endproperty
	a_m0_slow: assert property (p_m0_slow)
		else $error("slow shift clock not twelve cycles");
	property p_m0_fast;
		$fell(port0_txd) && mode_r == 3'h1 |=> !port0_txd ##1 port0_txd [*2];
	endproperty
	a_m0_fast: assert property (p_m0_fast)
		else $error("fast shift clock not four cycles");
	property p_m0_count;
		$fell(port0_rxd_oe) |-> falls_r == 4'h8;
	endproperty
	a_m0_count: assert property (p_m0_count)
		else $error("synchronous frame not eight clocks");
	property p_rd_hi;
		rvalid |-> rdata[31:8] == 24'h000000;
	endproperty
	a_rd_hi: assert property (p_rd_hi)
		else $error("read data wider than a byte");
	c_irq0: cover property ($rose(irq_port0));
	c_irq1: cover property ($rose(irq_port1));
	c_m0: cover property ($fell(port0_rxd_oe));
endmodule

// >>> tb/serial_node.sv
// remote serial node: drives both receive lines, samples the transmit lines
module serial_node (
	input wire logic aclk, // clock
	input wire logic txd0, // transmit lines, and-ed
	output logic rxd0, // port 0 receive line
	output logic rxd1 // port 1 receive line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rxd0 = 1'b1;
		rxd1 = 1'b1;
	end
	// start, n bits lsb first, stop; the line rests at mark level after
	task automatic send(input int p, input logic [8:0] b, input int n, input logic sb, input int bt);
		logic lv;
		for (int k = 0; k <= n + 2; k++) begin
			lv = (k == 0) ? 1'b0 : (k <= n) ? b[k-1] : (k == n + 1) ? sb : 1'b1;
			@(posedge aclk);
			if (p == 1) rxd1 <= lv;
			else rxd0 <= lv;
			repeat (bt - 1) @(posedge aclk);
		end
	endtask
	// mid-bit sampling of n data bits and the stop bit, then a quiet bit time
	task automatic cap(input int n, input int bt, output logic [9:0] v);
		v = 10'h000;
		while (txd0 !== 1'b0) @(posedge aclk);
		repeat (bt / 2) @(posedge aclk);
		for (int k = 0; k <= n; k++) begin
			repeat (bt) @(posedge aclk);
			v[k] = txd0;
		end
		repeat (bt) @(posedge aclk);
	endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the dual serial port
`include "dual_serial_port_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [9:0] awaddr = 10'h000, araddr = 10'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, port0_rxd_in, port0_rxd_out, port0_rxd_oe;
	logic port0_txd, port1_rxd_in, port1_rxd_out, port1_rxd_oe, port1_txd, node_rxd0;
	logic irq_port0, irq_port1, irq_level_port0, irq_level_port1;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int err_total = 0, n_checks = 0, cyc = 0;
	always #5 aclk = ~aclk;
	// the design owns the data pin while its synchronous transmit drives it
	assign port0_rxd_in = port0_rxd_oe ? port0_rxd_out : node_rxd0;
	dual_serial_port_addr_match dual_serial_port_addr_match_i (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .port0_rxd_in(port0_rxd_in),
		.port0_rxd_out(port0_rxd_out), .port0_rxd_oe(port0_rxd_oe), .port0_txd(port0_txd),
		.port1_rxd_in(port1_rxd_in), .port1_rxd_out(port1_rxd_out), .port1_rxd_oe(port1_rxd_oe),
		.port1_txd(port1_txd), .irq_port0(irq_port0), .irq_port1(irq_port1),
		.irq_level_port0(irq_level_port0), .irq_level_port1(irq_level_port1));
	serial_node serial_node_i (.aclk(aclk), .txd0(port0_txd & port1_txd), .rxd0(node_rxd0),
		.rxd1(port1_rxd_in));
	// hang guard, several times the expected run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			$display("MISMATCH t=%0t run did not finish", $time);
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// both channels offered together, each released once taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic a_ok;
		logic w_ok;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		a_ok = 1'b0;
		w_ok = 1'b0;
		while (!(a_ok && w_ok)) begin
			@(posedge aclk);
			if (awready && !a_ok) begin
				a_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		chk({30'h0, bresp}, 32'h0);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] msk);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		chk({22'h0, r, d[7:0] & msk}, {22'h0, `RESP_OKAY, exp});
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rdchk(`IDX_CTRL1, 8'h00, 8'hff);
		rdchk(`IDX_MASK0, 8'h00, 8'hff);
		rd(8'h10, d, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
	endtask
	// mode 1 at 16 clocks a bit, then mode 2 and mode 3 at 32
	task automatic t_tx;
		logic [9:0] v;
		wr(`IDX_MISC, 8'h16);
		wr(`IDX_CTRL0, 8'h40);
		fork
			serial_node_i.cap(8, 16, v);
			wr(`IDX_DATA0, 8'ha5);
		join
		chk({22'h0, v}, {22'h0, 2'b01, 8'ha5});
		rdchk(`IDX_CTRL0, 8'h42, 8'hff);
		chk({31'h0, irq_port0}, 32'h1);
		chk({31'h0, irq_level_port0}, 32'h1);
		wr(`IDX_MISC, 8'h44);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq_port0}, 32'h0);
		wr(`IDX_BAUD0, 8'h01);
		for (int k = 0; k < 2; k++) begin
			wr(`IDX_CTRL0, k[0] ? 8'hc8 : 8'h80);
			fork
				serial_node_i.cap(9, 32, v);
				wr(`IDX_DATA0, 8'h3c);
			join
			chk({22'h0, v}, {22'h0, 1'b1, k[0], 8'h3c});
		end
	endtask
	// mode 1 reception: disabled, accepted, overrun, framing fault
	task automatic t_rx;
		wr(`IDX_CTRL0, 8'h40);
		serial_node_i.send(0, 9'h03c, 8, 1'b1, 32);
		rdchk(`IDX_CTRL0, 8'h40, 8'hff);
		wr(`IDX_CTRL0, 8'h50);
		serial_node_i.send(0, 9'h03c, 8, 1'b1, 32);
		rdchk(`IDX_CTRL0, 8'h55, 8'hff);
		serial_node_i.send(0, 9'h0c3, 8, 1'b1, 32);
		rdchk(`IDX_DATA0, 8'h3c, 8'hff);
		wr(`IDX_MISC, 8'h01);
		wr(`IDX_CTRL0, 8'h50);
		serial_node_i.send(0, 9'h011, 8, 1'b0, 32);
		rdchk(`IDX_CTRL0, 8'h80, 8'h80);
		wr(`IDX_CTRL0, 8'h70);
		rdchk(`IDX_CTRL0, 8'h00, 8'h81);
		serial_node_i.send(0, 9'h022, 8, 1'b0, 32);
		rdchk(`IDX_CTRL0, 8'h80, 8'h81);
		wr(`IDX_MISC, 8'h00);
		rdchk(`IDX_CTRL0, 8'h00, 8'h80);
	endtask
	// mode 2 addressed reception against the station address and mask
	task automatic t_addr(input int p);
		logic [8:0] fr [4];
		logic [3:0] ex;
		logic [7:0] c;
		logic [9:0] v;
		fr = '{9'h05a, 9'h1aa, 9'h155, 9'h133};
		ex = 4'b1010;
		c = p ? `IDX_CTRL1 : `IDX_CTRL0;
		wr(`IDX_MISC, p ? 8'h4a : 8'h46);
		wr(p ? `IDX_PORT1_STATION_ADDRESS : `IDX_SADDR0, 8'h5a);
		for (int k = 0; k < 4; k++) begin
			wr(p ? `IDX_MASK1 : `IDX_MASK0, k == 3 ? 8'h00 : 8'h0f);
			wr(c, 8'hb0);
			serial_node_i.send(p, fr[k], 9, 1'b1, 32);
			rdchk(c, {5'h0, ex[k], 1'b0, ex[k]}, 8'h05);
			chk({31'h0, p ? irq_port1 : irq_port0}, {31'h0, ex[k]});
		end
		fork
			serial_node_i.cap(9, 32, v);
			wr(p ? `IDX_DATA1 : `IDX_DATA0, 8'h69);
		join
		chk({22'h0, v}, {22'h0, 2'b10, 8'h69});
	endtask
	// synchronous transmit: one shift clock period at each rate
	task automatic t_m0;
		int n;
		wr(`IDX_MISC, 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr(`IDX_CTRL0, k[0] ? 8'h20 : 8'h00);
			wr(`IDX_DATA0, 8'h96);
			while (port0_txd !== 1'b0) @(posedge aclk);
			n = 0;
			while (port0_txd === 1'b0) begin
				@(posedge aclk);
				n++;
			end
			while (port0_txd === 1'b1) begin
				@(posedge aclk);
				n++;
			end
			chk(n, k[0] ? 32'd4 : 32'd12);
			while (port0_rxd_oe !== 1'b0) @(posedge aclk);
			rdchk(`IDX_CTRL0, 8'h02, 8'h02);
		end
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_addr(0);
		t_addr(1);
		t_m0();
		complete_run();
	end
endmodule
bind dual_serial_port_addr_match serial_port_asserts serial_port_asserts_i (.aclk(aclk),
	.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
	.wvalid(wvalid), .wready(wready), .rdata(rdata), .rvalid(rvalid), .port0_txd(port0_txd),
	.port0_rxd_oe(port0_rxd_oe), .irq_port0(irq_port0), .irq_port1(irq_port1),
	.irq_level_port0(irq_level_port0), .irq_level_port1(irq_level_port1));
